// [src/loader_pkg.sv]
// Constants for the nonvolatile image loader of per-port configuration fields
// Behaviour
// RULE_01 - Image word 56h bit 0 becomes port 3 no-soft-reset configuration bit.
// RULE_02 - Word 56h bits 3:1 become port 3 auxiliary current field.
// RULE_03 - Word 56h bits 4 and 5 become port 3 D1 and D2 support flags.
// RULE_04 - Word 56h bits 7:6 become port 3 PME support for D2 and D1.
// RULE_05 - Word 56h bits 15:8 become port 3 PM data byte, default zero.
// RULE_06 - Words 58h to 5Eh load ports 0 to 3 link-layer control words whole.
// RULE_07 - Port word bit 1 loads slot clock configuration; set means connector clock.
// RULE_08 - Port word bit 2 loads the device-specific-initialization-required flag.
// RULE_09 - Port word bit 3 puts VC1 into the low-priority channel group.
// RULE_10 - Port word bits 6:4 load the logical port number.
// RULE_11 - Port word bits 15:9 load the TC-to-VC0 map bits 7:1.
// RULE_12 - Word 62h bit 0 loads port 1 slot-implemented; defaults 12h and 02h.
// RULE_13 - All fields load before configuration is accepted; unloaded fields keep defaults.
`default_nettype none
package loader_pkg;
	// Image word byte addresses and fetch order
	localparam logic [7:0]  IMG_BASE_ADDR  = 8'h56;
	localparam int          WORD_CNT       = 7;
	localparam logic [2:0]  IDX_P3_PM      = 3'h0;
	localparam logic [2:0]  IDX_LINK0      = 3'h1;
	localparam logic [2:0]  IDX_P0_CFG     = 3'h5;
	localparam logic [2:0]  IDX_P1_CFG     = 3'h6;
	localparam logic [2:0]  IDX_LAST       = 3'h6;

	// Reset images of the stored words
	localparam logic [15:0] PM_WORD_RST    = 16'h00FF;
	localparam logic [15:0] LINK_WORD_RST  = 16'h0000;
	localparam logic [15:0] P0_WORD_RST    = 16'hFE02;
	localparam logic [15:0] P1_WORD_RST    = 16'hFE12;

	// Port 3 power management word fields
	localparam int          PM_NSR_BIT     = 0;
	localparam int          PM_AUX_LSB     = 1;
	localparam int          PM_D1_BIT      = 4;
	localparam int          PM_D2_BIT      = 5;
	localparam int          PM_PME_LSB     = 6;
	localparam int          PM_DATA_LSB    = 8;

	// Per-port configuration word fields
	localparam int          PW_SLOT_BIT    = 0;
	localparam int          PW_SCLK_BIT    = 1;
	localparam int          PW_DSI_BIT     = 2;
	localparam int          PW_LOW_PRIORITY_VC_GROUP_BIT    = 3;
	localparam int          PW_PNUM_LSB    = 4;
	localparam int          PW_TCMAP_LSB   = 9;

	// Register byte addresses
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h04;
	localparam logic [7:0]  REG_PM_WORD    = 8'h08;
	localparam logic [7:0]  REG_LINK0      = 8'h0C;
	localparam logic [7:0]  REG_PORT0      = 8'h1C;
	localparam logic [7:0]  REG_PORT1      = 8'h20;

	// Control register fields
	localparam int          CTRL_RESTART   = 0;
	localparam int          CTRL_HOLD      = 1;
	localparam logic        CTRL_HOLD_RST  = 1'b0;
endpackage
`default_nettype wire

// [src/loader_if.sv]
// Carrier between the image fetch sequencer and the field store
`default_nettype none
interface loader_if;
	logic        start;
	logic        hold;
	logic        ee_req;
	logic [7:0]  ee_addr;
	logic        ee_ack;
	logic [15:0] ee_rdata;
	logic        ee_absent;
	logic        word_valid;
	logic [2:0]  word_idx;
	logic [15:0] word_data;
	logic        busy;
	logic        done;
	logic        absent;

	modport fetch (
		input  start, hold, ee_ack, ee_rdata, ee_absent,
		output ee_req, ee_addr, word_valid, word_idx, word_data, busy, done, absent
	);
	modport core (
		output start, hold, ee_ack, ee_rdata, ee_absent,
		input  ee_req, ee_addr, word_valid, word_idx, word_data, busy, done, absent
	);
endinterface
`default_nettype wire

// [src/image_fetch.sv]
// Sequencer that requests the image words one by one from the EEPROM reader
`default_nettype none
module image_fetch (
	input  wire logic pclk,
	input  wire logic presetn,
	loader_if.fetch   lif
);
	typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_DONE} fetch_state_e;

	fetch_state_e state_q;
	logic [2:0]   idx_q;
	logic [7:0]   addr_q;
	logic         valid_q;
	logic [2:0]   widx_q;
	logic [15:0]  wdata_q;
	logic         absent_q;

	// Missing image ends the walk at once so every field not yet loaded keeps its default
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (lif.ee_absent) begin
						state_q <= ST_DONE; // [RULE_13]
					end else if (!lif.hold) begin
						state_q <= ST_REQ;
					end
				end
				ST_REQ: begin
					if (lif.ee_absent) begin
						state_q <= ST_DONE;
					end else if (lif.ee_ack && idx_q == loader_pkg::IDX_LAST) begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					if (lif.start) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_q  <= 3'h0;
			addr_q <= loader_pkg::IMG_BASE_ADDR;
		end else if (state_q == ST_IDLE) begin
			idx_q  <= 3'h0;
			addr_q <= loader_pkg::IMG_BASE_ADDR;
		end else if (state_q == ST_REQ && lif.ee_ack && !lif.ee_absent) begin
			idx_q  <= idx_q + 3'h1;
			addr_q <= addr_q + 8'h02; // [RULE_06]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_q <= 1'b0;
			widx_q  <= 3'h0;
			wdata_q <= 16'h0000;
		end else begin
			valid_q <= (state_q == ST_REQ) && lif.ee_ack && !lif.ee_absent;
			if (state_q == ST_REQ && lif.ee_ack) begin
				widx_q  <= idx_q;
				wdata_q <= lif.ee_rdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			absent_q <= 1'b0;
		end else if (state_q != ST_DONE && lif.ee_absent) begin
			absent_q <= 1'b1;
		end else if (state_q == ST_DONE && lif.start) begin
			absent_q <= 1'b0;
		end
	end

	assign lif.ee_req     = (state_q == ST_REQ);
	assign lif.ee_addr    = addr_q;
	assign lif.word_valid = valid_q;
	assign lif.word_idx   = widx_q;
	assign lif.word_data  = wdata_q;
	assign lif.busy       = (state_q != ST_DONE);
	assign lif.done       = (state_q == ST_DONE);
	assign lif.absent     = absent_q;
endmodule
`default_nettype wire

// [src/eeprom_port_config_loader.sv]
// Loader that copies image words into per-port configuration fields, with APB access
//
// Added by the designer: the register addresses and register access over APB.
`default_nettype none
module eeprom_port_config_loader (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   ee_req,
	output logic [7:0]             ee_addr,
	input  wire logic              ee_ack,
	input  wire logic [15:0]       ee_rdata,
	input  wire logic              ee_absent,
	output logic                   cfg_ready,
	output logic                   no_soft_reset_p3,
	output logic [2:0]             aux_current_p3,
	output logic                   d1_support_p3,
	output logic                   d2_support_p3,
	output logic [1:0]             pme_support_p3,
	output logic [7:0]             pm_data_p3,
	output logic [3:0][15:0]       link_layer_control_word,
	output logic [1:0]             slot_clock_cfg,
	output logic [1:0]             dsi_required,
	output logic [1:0]             low_priority_vc_group,
	output logic [1:0][2:0]        port_number,
	output logic [1:0][6:0]        tc_vc0_map,
	output logic                   slot_implemented_p1
);
	loader_if lif ();

	logic             hold_q;
	logic             restart;
	logic             ready_q;
	logic [15:0]      pm_word_q;
	logic [15:0]      link_q [4];
	logic [15:0]      port_q [2];
	logic [31:0]      rdata_q;
	logic             err_q;
	logic [2:0]       loaded_q;

	// True when the captured word targets the given fetch index
	function automatic logic word_hit(input logic vld, input logic [2:0] idx,
		input logic [2:0] want);
		word_hit = vld && (idx == want);
	endfunction

	image_fetch u_fetch (
		.pclk    (pclk),
		.presetn (presetn),
		.lif     (lif.fetch)
	);

	assign lif.start     = restart;
	assign lif.hold      = hold_q;
	assign lif.ee_ack    = ee_ack;
	assign lif.ee_rdata  = ee_rdata;
	assign lif.ee_absent = ee_absent;
	assign ee_req        = lif.ee_req;
	assign ee_addr       = lif.ee_addr;

	wire logic setup  = psel && !penable;
	wire logic access = psel && penable;

	// Restart is honoured only once the walk is done, so a walk never restarts half way
	assign restart = access && pwrite && (paddr == loader_pkg::REG_CTRL)
		&& pwdata[loader_pkg::CTRL_RESTART] && lif.done && !lif.word_valid;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= loader_pkg::CTRL_HOLD_RST;
		end else if (access && pwrite && paddr == loader_pkg::REG_CTRL) begin
			hold_q <= pwdata[loader_pkg::CTRL_HOLD];
		end
	end

	// Ready follows the field store by one edge so the last word lands first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= lif.done && !restart && !lif.word_valid; // [RULE_13]
		end
	end
	assign cfg_ready = ready_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_q <= 3'h0;
		end else if (restart) begin
			loaded_q <= 3'h0;
		end else if (lif.word_valid) begin
			loaded_q <= loaded_q + 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_word_q <= loader_pkg::PM_WORD_RST;
		end else if (restart) begin
			pm_word_q <= loader_pkg::PM_WORD_RST; // [RULE_13]
		end else if (word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P3_PM)) begin
			pm_word_q <= lif.word_data; // [RULE_01] [RULE_05]
		end
	end

	generate
		for (genvar p = 0; p < 4; p++) begin : g_link
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					link_q[p] <= loader_pkg::LINK_WORD_RST;
				end else if (restart) begin
					link_q[p] <= loader_pkg::LINK_WORD_RST;
				end else if (word_hit(lif.word_valid, lif.word_idx,
					loader_pkg::IDX_LINK0 + 3'(p))) begin
					link_q[p] <= lif.word_data; // [RULE_06]
				end
			end
			assign link_layer_control_word[p] = link_q[p];
		end
		for (genvar p = 0; p < 2; p++) begin : g_port
			localparam logic [15:0] RST = (p == 0) ? loader_pkg::P0_WORD_RST
				: loader_pkg::P1_WORD_RST;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_q[p] <= RST; // [RULE_12]
				end else if (restart) begin
					port_q[p] <= RST;
				end else if (word_hit(lif.word_valid, lif.word_idx,
					loader_pkg::IDX_P0_CFG + 3'(p))) begin
					port_q[p] <= lif.word_data; // [RULE_07] [RULE_11]
				end
			end
			assign slot_clock_cfg[p]        = port_q[p][loader_pkg::PW_SCLK_BIT]; // [RULE_07]
			assign dsi_required[p]          = port_q[p][loader_pkg::PW_DSI_BIT]; // [RULE_08]
			assign low_priority_vc_group[p] = port_q[p][loader_pkg::PW_LOW_PRIORITY_VC_GROUP_BIT]; // [RULE_09]
			assign port_number[p]           = port_q[p][loader_pkg::PW_PNUM_LSB +: 3]; // [RULE_10]
			assign tc_vc0_map[p]            = port_q[p][loader_pkg::PW_TCMAP_LSB +: 7]; // [RULE_11]
		end
	endgenerate

	assign slot_implemented_p1 = port_q[1][loader_pkg::PW_SLOT_BIT]; // [RULE_12]
	assign no_soft_reset_p3    = pm_word_q[loader_pkg::PM_NSR_BIT]; // [RULE_01]
	assign aux_current_p3      = pm_word_q[loader_pkg::PM_AUX_LSB +: 3]; // [RULE_02]
	assign d1_support_p3       = pm_word_q[loader_pkg::PM_D1_BIT]; // [RULE_03]
	assign d2_support_p3       = pm_word_q[loader_pkg::PM_D2_BIT]; // [RULE_03]
	assign pme_support_p3      = pm_word_q[loader_pkg::PM_PME_LSB +: 2]; // [RULE_04]
	assign pm_data_p3          = pm_word_q[loader_pkg::PM_DATA_LSB +: 8]; // [RULE_05]

	// Read data is sampled in the setup cycle, so the slave never waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h00000000;
			err_q   <= 1'b0;
		end else if (setup) begin
			err_q   <= 1'b0;
			rdata_q <= 32'h00000000;
			if (paddr == loader_pkg::REG_CTRL) begin
				rdata_q[loader_pkg::CTRL_HOLD] <= hold_q;
			end else if (paddr == loader_pkg::REG_STATUS) begin
				rdata_q[6:0] <= {loaded_q, 1'b0, lif.absent, lif.busy, ready_q};
			end else if (paddr == loader_pkg::REG_PM_WORD) begin
				rdata_q[15:0] <= pm_word_q;
			end else if (paddr >= loader_pkg::REG_LINK0 && paddr < loader_pkg::REG_PORT0
				&& paddr[1:0] == 2'h0) begin
				rdata_q[15:0] <= link_q[2'((paddr - loader_pkg::REG_LINK0) >> 2)];
			end else if (paddr == loader_pkg::REG_PORT0) begin
				rdata_q[15:0] <= port_q[0];
			end else if (paddr == loader_pkg::REG_PORT1) begin
				rdata_q[15:0] <= port_q[1];
			end else begin
				err_q <= 1'b1;
			end
		end
	end

	assign prdata  = rdata_q;
	assign pready  = 1'b1;
	assign pslverr = access && err_q;

	// One-hot view of the stored word that lands this cycle, used by the checks below
	logic [6:0] word_land;
	assign word_land = lif.word_valid ? (7'h01 << lif.word_idx) : 7'h00;

	AST_NSR_P3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P3_PM)
		|=> no_soft_reset_p3 == $past(lif.word_data[0]))
		else $error("port 3 no-soft-reset not loaded from word bit 0");

	AST_AUX_P3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P3_PM)
		|=> aux_current_p3 == $past(lif.word_data[3:1]))
		else $error("port 3 aux current not loaded from word bits 3:1");

	AST_D1D2_P3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P3_PM)
		|=> {d2_support_p3, d1_support_p3} == $past(lif.word_data[5:4]))
		else $error("port 3 D1 or D2 support flag wrong");

	AST_PME_P3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P3_PM)
		|=> pme_support_p3 == $past(lif.word_data[7:6]))
		else $error("port 3 PME support not loaded from word bits 7:6");

	AST_PMDATA_P3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
		!lif.word_valid |=> $stable(pm_data_p3) || $past(restart))
		else $error("port 3 PM data changed without a loaded word");

	AST_LINK2: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		ee_req && ee_ack && !ee_absent && ee_addr == 8'h5C
		|=> ##1 link_layer_control_word[2] == $past(ee_rdata, 2))
		else $error("word 5Ch not copied to port 2 link-layer control");

	AST_SCLK_P0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P0_CFG)
		|=> slot_clock_cfg[0] == $past(lif.word_data[1]) && $stable(slot_clock_cfg[1]))
		else $error("port 0 slot clock bit wrong or port 1 disturbed");

	AST_DSI_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P1_CFG)
		|=> dsi_required[1] == $past(lif.word_data[2]))
		else $error("port 1 DSI-required flag wrong");

	AST_LOW_PRIORITY_VC_GROUP_P0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P0_CFG)
		|=> low_priority_vc_group[0] == $past(lif.word_data[3]))
		else $error("port 0 low-priority VC group bit wrong");

	AST_PNUM_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P1_CFG)
		|=> port_number[1] == $past(lif.word_data[6:4]))
		else $error("port 1 logical port number wrong");

	AST_TCMAP_P0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		word_hit(lif.word_valid, lif.word_idx, loader_pkg::IDX_P0_CFG)
		|=> tc_vc0_map[0] == $past(lif.word_data[15:9]))
		else $error("port 0 TC to VC0 map wrong");

	AST_SLOT_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		restart |=> slot_implemented_p1 == 1'b0 && port_q[1] == loader_pkg::P1_WORD_RST
		&& port_q[0] == loader_pkg::P0_WORD_RST)
		else $error("port word defaults not restored");

	AST_READY: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		cfg_ready |-> !lif.busy && !lif.word_valid)
		else $error("configuration accepted while fields still loading");

	AST_LINK0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		word_land[loader_pkg::IDX_LINK0]
		|=> link_layer_control_word[0] == $past(lif.word_data))
		else $error("link word 0 not loaded");

	AST_LINK1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		word_land[loader_pkg::IDX_LINK0 + 1]
		|=> link_layer_control_word[1] == $past(lif.word_data))
		else $error("link word 1 not loaded");

	AST_LINK3: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		word_land[loader_pkg::IDX_LINK0 + 3]
		|=> link_layer_control_word[3] == $past(lif.word_data))
		else $error("link word 3 not loaded");

	AST_SCLK_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
		word_land[loader_pkg::IDX_P1_CFG]
		|=> slot_clock_cfg[1] == $past(lif.word_data[1]))
		else $error("port 1 slot clock bit wrong");

	AST_DSI_P0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
		word_land[loader_pkg::IDX_P0_CFG]
		|=> dsi_required[0] == $past(lif.word_data[2]))
		else $error("port 0 DSI-required flag wrong");

	AST_LOW_PRIORITY_VC_GROUP_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
		word_land[loader_pkg::IDX_P1_CFG]
		|=> low_priority_vc_group[1] == $past(lif.word_data[3]))
		else $error("port 1 low-priority VC group bit wrong");

	AST_PNUM_P0: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
		word_land[loader_pkg::IDX_P0_CFG]
		|=> port_number[0] == $past(lif.word_data[6:4]))
		else $error("port 0 logical port number wrong");

	AST_TCMAP_P1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
		word_land[loader_pkg::IDX_P1_CFG]
		|=> tc_vc0_map[1] == $past(lif.word_data[15:9]))
		else $error("port 1 TC to VC0 map wrong");

	AST_SLOT_LOAD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
		word_land[loader_pkg::IDX_P1_CFG]
		|=> slot_implemented_p1 == $past(lif.word_data[0]))
		else $error("port 1 slot-implemented bit wrong");

	AST_PM_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
		restart
		|=> pm_word_q == loader_pkg::PM_WORD_RST)
		else $error("port 3 power word default not restored");

	AST_LINK_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		restart
		|=> link_layer_control_word == {4{loader_pkg::LINK_WORD_RST}})
		else $error("link word defaults not restored");

	AST_READY_CLR: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		restart
		|=> !cfg_ready)
		else $error("ready kept across a restart");

	AST_ADDR_STEP: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		ee_req && ee_ack && !ee_absent
		|=> ee_addr == $past(ee_addr) + 8'h02)
		else $error("image address did not step to the next word");

	AST_ADDR_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
		ee_req && !ee_ack
		|=> $stable(ee_addr))
		else $error("image address moved before its word came");

	AST_ABSENT_END: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		ee_absent && lif.busy
		|=> lif.done && !ee_req)
		else $error("walk not ended by a missing image");

	AST_HOLD_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		lif.hold && !ee_req
		|=> !ee_req)
		else $error("walk started while held");

	AST_LOAD_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		cfg_ready && !lif.absent
		|-> loaded_q == 3'(loader_pkg::WORD_CNT))
		else $error("ready with words still missing");

	AST_PORT0_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
		lif.done && !restart
		|=> $stable(port_q[0]))
		else $error("port 0 word changed after the walk");
endmodule
`default_nettype wire

// [testbench/eeprom_image_model.sv]
// Behavioural serial EEPROM that answers image word requests with preload words
`default_nettype none
module eeprom_image_model (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ee_req,
	input  wire logic [7:0]       ee_addr,
	input  wire logic [6:0][15:0] image,
	input  wire logic [3:0]       wait_cycles,
	input  wire logic             absent_in,
	output logic                  ee_ack,
	output logic [15:0]           ee_rdata,
	output logic                  ee_absent
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0]  cnt_q;
	logic [7:0]  off;
	logic [15:0] word;

	assign off = ee_addr - 8'h56;
	assign word = (off[3:1] <= 3'h6 && !off[0]) ? image[off[3:1]] : 16'hFFFF;
	assign ee_absent = absent_in;

	// Data is only good in the ack cycle; it toggles otherwise so stale use shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			ee_ack <= 1'b0;
			ee_rdata <= 16'hA55A;
		end else begin
			ee_ack <= 1'b0;
			ee_rdata <= ~ee_rdata;
			if (ee_req && !ee_ack && !absent_in) begin
				if (cnt_q >= wait_cycles) begin
					ee_ack <= 1'b1;
					ee_rdata <= word;
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/eeprom_port_config_loader_tb.sv]
// Self-checking bench for the image loader with an EEPROM model and APB master
`default_nettype none
module eeprom_port_config_loader_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, ee_req, ee_ack, ee_absent, cfg_ready, no_soft_reset_p3;
	logic d1_support_p3, d2_support_p3, slot_implemented_p1, err;
	logic [7:0]  ee_addr, pm_data_p3;
	logic [15:0] ee_rdata;
	logic [2:0]  aux_current_p3;
	logic [1:0]  pme_support_p3, slot_clock_cfg, dsi_required, low_priority_vc_group;
	logic [3:0][15:0] link_layer_control_word;
	logic [1:0][2:0]  port_number;
	logic [1:0][6:0]  tc_vc0_map;
	logic [6:0][15:0] image, img1, def;
	logic [3:0] wait_cycles = 4'h0;
	logic       absent_in = 1'b0;
	int bad_count = 0, total_checks = 0, ack_cnt = 0;

	always #50 pclk = ~pclk;

	eeprom_port_config_loader u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_req(ee_req),
		.ee_addr(ee_addr), .ee_ack(ee_ack), .ee_rdata(ee_rdata), .ee_absent(ee_absent),
		.cfg_ready(cfg_ready), .no_soft_reset_p3(no_soft_reset_p3),
		.aux_current_p3(aux_current_p3), .d1_support_p3(d1_support_p3),
		.d2_support_p3(d2_support_p3), .pme_support_p3(pme_support_p3),
		.pm_data_p3(pm_data_p3), .link_layer_control_word(link_layer_control_word),
		.slot_clock_cfg(slot_clock_cfg), .dsi_required(dsi_required),
		.low_priority_vc_group(low_priority_vc_group), .port_number(port_number),
		.tc_vc0_map(tc_vc0_map), .slot_implemented_p1(slot_implemented_p1));

	eeprom_image_model u_eeprom (.pclk(pclk), .presetn(presetn), .ee_req(ee_req),
		.ee_addr(ee_addr), .image(image), .wait_cycles(wait_cycles),
		.absent_in(absent_in), .ee_ack(ee_ack), .ee_rdata(ee_rdata),
		.ee_absent(ee_absent));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Words must be taken strictly in image order, one per accepted ack
	always @(posedge pclk) begin
		if (presetn && ee_req === 1'b1 && ee_ack === 1'b1 && ee_absent === 1'b0) begin
			chk("ee_addr", {24'h0, ee_addr}, 32'h56 + 32'(2 * ack_cnt));
			ack_cnt++;
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(pready), 32'h1);
	endtask

	task automatic wait_ready(input logic lvl);
		int n;
		n = 0;
		while (cfg_ready !== lvl && n < 500) begin
			@(posedge pclk);
			n++;
		end
		chk("cfg_ready", 32'(cfg_ready), 32'(lvl));
	endtask

	task automatic check_fields(input logic [6:0][15:0] w);
		chk("nsr", 32'(no_soft_reset_p3), 32'(w[0][0]));
		chk("aux", 32'(aux_current_p3), 32'(w[0][3:1]));
		chk("d1", 32'(d1_support_p3), 32'(w[0][4]));
		chk("d2", 32'(d2_support_p3), 32'(w[0][5]));
		chk("pme", 32'(pme_support_p3), 32'(w[0][7:6]));
		chk("pm_data", 32'(pm_data_p3), 32'(w[0][15:8]));
		for (int i = 0; i < 4; i++) begin
			chk("link", 32'(link_layer_control_word[i]), 32'(w[1+i]));
		end
		for (int p = 0; p < 2; p++) begin
			chk("slot_clk", 32'(slot_clock_cfg[p]), 32'(w[5+p][1]));
			chk("dsi", 32'(dsi_required[p]), 32'(w[5+p][2]));
			chk("low_priority_vc_group", 32'(low_priority_vc_group[p]), 32'(w[5+p][3]));
			chk("port_num", 32'(port_number[p]), 32'(w[5+p][6:4]));
			chk("tc_map", 32'(tc_vc0_map[p]), 32'(w[5+p][15:9]));
		end
		chk("slot_impl", 32'(slot_implemented_p1), 32'(w[6][0]));
	endtask

	task automatic s_reset_defaults();
		check_fields(def);
		chk("cfg_ready_rst", 32'(cfg_ready), 32'h0);
	endtask

	task automatic s_walk();
		wait_ready(1'b1);
		chk("ack_count", 32'(ack_cnt), 32'h7);
		check_fields(img1);
	endtask

	task automatic s_regs();
		apb(1'b0, 8'h04, 32'h0);
		chk("status", rd, 32'h71);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'h0C + 8'(4 * i), 32'h0);
			chk("link_reg", rd, {16'h0, img1[1+i]});
		end
		apb(1'b0, 8'h08, 32'h0);
		chk("pm_word", rd, {16'h0, img1[0]});
		apb(1'b0, 8'h20, 32'h0);
		chk("port1_word", rd, {16'h0, img1[6]});
		apb(1'b1, 8'h1C, 32'h0000FFFF);
		apb(1'b0, 8'h1C, 32'h0);
		chk("port0_ro", rd, {16'h0, img1[5]});
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped_err", 32'(err), 32'h1);
		chk("unmapped_data", rd, 32'h0);
	endtask

	// A held restart must show defaults until the walk is released
	task automatic s_hold_restart();
		image <= ~img1;
		wait_cycles <= 4'h3;
		apb(1'b1, 8'h00, 32'h3);
		wait_ready(1'b0);
		ack_cnt = 0;
		repeat (10) @(posedge pclk);
		chk("held_req", 32'(ee_req), 32'h0);
		check_fields(def);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl_hold", rd, 32'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk("status_held", rd, 32'h2);
		apb(1'b1, 8'h00, 32'h0);
		wait_ready(1'b1);
		chk("ack_count2", 32'(ack_cnt), 32'h7);
		check_fields(~img1);
	endtask

	task automatic s_absent();
		absent_in <= 1'b1;
		apb(1'b1, 8'h00, 32'h1);
		wait_ready(1'b0);
		ack_cnt = 0;
		wait_ready(1'b1);
		check_fields(def);
		chk("absent_acks", 32'(ack_cnt), 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk("absent_flag", 32'(rd[2]), 32'h1);
	endtask

	initial begin
		def = {16'hFE12, 16'hFE02, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF};
		img1 = {16'h5A6D, 16'hA4B6, 16'h1234, 16'h8001, 16'hC3F0, 16'h7E5A, 16'hA55A};
		image = img1;
		repeat (20) @(posedge pclk);
		s_reset_defaults();
		presetn <= 1'b1;
		s_walk();
		s_regs();
		s_hold_restart();
		s_absent();
		results();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
